// ### hdl/frg_guard.sv
/*
 * Flash rewrite guard: command sequencer in front of the flash array with
 * block enable and lock gating, serial ID check and parallel code protect.
 * Assumes mode_i is stable while operating and the flash array answers
 * every request with one fl_done_i pulse.
 */
`timescale 1ns/1ps
`include "frg_cfg.svh"

module frg_guard (
  input wire logic clock_i, // 200 MHz system clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic [1:0] mode_i, // operating mode pins
  input wire logic pgm_valid_i, // programmer command request
  input wire logic [2:0] pgm_cmd_i, // programmer command code
  input wire logic [19:0] pgm_addr_i, // programmer flash address
  input wire logic [7:0] pgm_data_i, // programmer write byte
  input wire logic pgm_id_we_i, // programmer ID byte strobe
  input wire logic [2:0] pgm_id_idx_i, // programmer ID byte index
  output logic pgm_ack_o, // command done pulse
  output logic pgm_nak_o, // command refused pulse
  output logic [7:0] pgm_rdata_o, // read or status byte
  output logic fl_req_o, // flash operation request
  output logic [1:0] fl_op_o, // flash operation code
  output logic [19:0] fl_addr_o, // flash byte address
  output logic [7:0] fl_wdata_o, // flash program byte
  input wire logic [7:0] fl_rdata_i, // flash read byte
  input wire logic fl_done_i, // flash operation done
  output logic fl_boot_area_o, // fetch from boot area
  output logic cpu_stall_o // hold cpu fetch from flash
);

  frg_pkg::frg_state_type state;
  logic [1:0] mode_q;
  logic [2:0] ctrl_a;
  logic [1:0] ctrl_b;
  logic [19:0] addr_reg;
  logic [7:0] rd_data;
  logic [7:0] opt_byte;
  logic [2:0] samp_idx;
  logic refused;
  logic op_from_pgm;
  logic id_ok;

  logic wb_req;
  logic cpu_cmd;
  logic pgm_take;
  logic [2:0] cmd;
  logic [19:0] cmd_addr;
  logic [7:0] cmd_data;
  logic cmd_take;
  logic cmd_ok;
  logic cmd_flash;
  logic set_refuse;
  logic clr_refuse;
  logic protect;
  logic [7:0] status;
  frg_pkg::frg_block_type cmd_blk;

  function automatic frg_pkg::frg_block_type blk_of(input logic [19:0] a);
    if (a >= `FRG_BLK0_LO && a <= `FRG_BLK0_HI) begin
      blk_of = frg_pkg::FRG_BLK_0;
    end else if (a >= `FRG_BLK1_LO && a <= `FRG_BLK1_HI) begin
      blk_of = frg_pkg::FRG_BLK_1;
    end else if (a >= `FRG_BLKA_LO && a <= `FRG_BLKA_HI) begin
      blk_of = frg_pkg::FRG_BLK_A;
    end else if (a >= `FRG_BLKB_LO && a <= `FRG_BLKB_HI) begin
      blk_of = frg_pkg::FRG_BLK_B;
    end else begin
      blk_of = frg_pkg::FRG_BLK_NONE;
    end
  endfunction

  function automatic logic [19:0] samp_addr(input logic [2:0] i);
    case (i)
      3'h0: samp_addr = `FRG_ID0_ADDR;
      3'h1: samp_addr = `FRG_ID1_ADDR;
      3'h2: samp_addr = `FRG_ID2_ADDR;
      3'h3: samp_addr = `FRG_ID3_ADDR;
      3'h4: samp_addr = `FRG_ID4_ADDR;
      3'h5: samp_addr = `FRG_ID5_ADDR;
      3'h6: samp_addr = `FRG_ID6_ADDR;
      default: samp_addr = `FRG_OPT_ADDR;
    endcase
  endfunction

  assign protect = !opt_byte[`FRG_OPT_PROT_BIT] && opt_byte[`FRG_OPT_QUAL_BIT];

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cpu_cmd = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `FRG_REG_CMD;

  assign pgm_take = (state == frg_pkg::FRG_ST_READY) && pgm_valid_i
    && (mode_q != `FRG_MODE_SINGLE) && !cpu_cmd;

  always_comb begin
    if (pgm_take) begin
      cmd = pgm_cmd_i;
      cmd_addr = pgm_addr_i;
      cmd_data = pgm_data_i;
    end else begin
      cmd = wb_dat_i[10:8];
      cmd_addr = addr_reg;
      cmd_data = wb_dat_i[7:0];
    end
  end

  assign cmd_blk = blk_of(cmd_addr);

  assign cmd_take = (state == frg_pkg::FRG_ST_READY)
    && ((cpu_cmd && mode_q == `FRG_MODE_SINGLE)
      || (pgm_take && (mode_q != `FRG_MODE_BOOT || id_ok)));

  assign cmd_flash = cmd == `FRG_CMD_READ || cmd == `FRG_CMD_PROG
    || cmd == `FRG_CMD_ERASE;

  always_comb begin
    cmd_ok = 1'b1;
    if (cmd > `FRG_CMD_ERASE) begin
      cmd_ok = 1'b0;
    end else if (cmd_flash && cmd_blk == frg_pkg::FRG_BLK_NONE) begin
      cmd_ok = 1'b0;
    end else if (mode_q == `FRG_MODE_PARALLEL) begin
      if (cmd_flash && protect) begin
        cmd_ok = 1'b0;
      end
    end else if (mode_q == `FRG_MODE_SINGLE
      && (cmd == `FRG_CMD_PROG || cmd == `FRG_CMD_ERASE)) begin
      // a cpu rewrite sub-mode must be selected
      if (!ctrl_a[`FRG_A_RAM_EXEC] && !ctrl_a[`FRG_A_FLASH_EXEC]) begin
        cmd_ok = 1'b0;
      end
      if ((cmd_blk == frg_pkg::FRG_BLK_0 || cmd_blk == frg_pkg::FRG_BLK_1)
        && !ctrl_a[`FRG_A_PROG_EN]) begin
        cmd_ok = 1'b0;
      end
      if (cmd_blk == frg_pkg::FRG_BLK_0 && ctrl_b[`FRG_B_LOCK0]) begin
        cmd_ok = 1'b0;
      end
      if (cmd_blk == frg_pkg::FRG_BLK_1 && ctrl_b[`FRG_B_LOCK1]) begin
        cmd_ok = 1'b0;
      end
    end
  end

  // busy cpu command writes and forbidden commands mark the refusal flag
  assign set_refuse = (cpu_cmd && !cmd_take) || (cmd_take && !cmd_ok);
  assign clr_refuse = cmd_take && cmd_ok && cmd == `FRG_CMD_CLEAR;

  assign status = {2'b00, mode_q, protect, id_ok, refused,
    state == frg_pkg::FRG_ST_BUSY};

  frg_id_check u_id (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .clear_i(state == frg_pkg::FRG_ST_IDLE),
    .st_we_i(state == frg_pkg::FRG_ST_SAMPLE && fl_done_i && samp_idx != 3'h7),
    .st_idx_i(samp_idx),
    .st_byte_i(fl_rdata_i),
    .rx_we_i(pgm_id_we_i && mode_q == `FRG_MODE_BOOT),
    .rx_idx_i(pgm_id_idx_i),
    .rx_byte_i(pgm_data_i),
    .id_ok_o(id_ok)
  );

  // sequencer: one flash operation at a time
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= frg_pkg::FRG_ST_IDLE;
      mode_q <= `FRG_MODE_SINGLE;
      samp_idx <= 3'h0;
      op_from_pgm <= 1'b0;
      fl_req_o <= 1'b0;
      fl_op_o <= `FRG_OP_READ;
      fl_addr_o <= 20'h00000;
      fl_wdata_o <= 8'h00;
    end else begin
      case (state)
        frg_pkg::FRG_ST_IDLE: begin
          mode_q <= mode_i;
          samp_idx <= 3'h0;
          state <= frg_pkg::FRG_ST_SAMPLE;
        end
        frg_pkg::FRG_ST_SAMPLE: begin
          if (!fl_req_o) begin
            fl_req_o <= 1'b1;
            fl_op_o <= `FRG_OP_READ;
            fl_addr_o <= samp_addr(samp_idx);
          end else if (fl_done_i) begin
            fl_req_o <= 1'b0;
            samp_idx <= samp_idx + 3'h1;
            if (samp_idx == 3'h7) begin
              state <= frg_pkg::FRG_ST_READY;
            end
          end
        end
        frg_pkg::FRG_ST_READY: begin
          if (mode_i != mode_q) begin
            state <= frg_pkg::FRG_ST_IDLE;
          end else if (cmd_take) begin
            op_from_pgm <= pgm_take;
            if (cmd_ok && cmd_flash) begin
              fl_req_o <= 1'b1;
              fl_addr_o <= cmd_addr;
              fl_wdata_o <= cmd_data;
              if (cmd == `FRG_CMD_PROG) begin
                fl_op_o <= `FRG_OP_PROG;
              end else if (cmd == `FRG_CMD_ERASE) begin
                fl_op_o <= `FRG_OP_ERASE;
              end else begin
                fl_op_o <= `FRG_OP_READ;
              end
              state <= frg_pkg::FRG_ST_BUSY;
            end else if (pgm_take) begin
              state <= frg_pkg::FRG_ST_HOLD;
            end
          end
        end
        frg_pkg::FRG_ST_BUSY: begin
          if (fl_done_i) begin
            fl_req_o <= 1'b0;
            state <= op_from_pgm ? frg_pkg::FRG_ST_HOLD : frg_pkg::FRG_ST_READY;
          end
        end
        frg_pkg::FRG_ST_HOLD: begin
          // wait for the programmer to drop its request so it is not retaken
          if (!pgm_valid_i) begin
            state <= frg_pkg::FRG_ST_READY;
          end
        end
        default: begin
          state <= frg_pkg::FRG_ST_IDLE;
        end
      endcase
    end
  end

  // option byte copy, lifted by an erase of its block
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opt_byte <= `FRG_ERASED_BYTE;
    end else if (state == frg_pkg::FRG_ST_SAMPLE && fl_done_i && samp_idx == 3'h7) begin
      opt_byte <= fl_rdata_i;
    end else if (state == frg_pkg::FRG_ST_BUSY && fl_done_i && fl_op_o == `FRG_OP_ERASE
      && blk_of(fl_addr_o) == frg_pkg::FRG_BLK_0) begin
      opt_byte <= `FRG_ERASED_BYTE;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data <= 8'h00;
    end else if (state == frg_pkg::FRG_ST_BUSY && fl_done_i && fl_op_o == `FRG_OP_READ) begin
      rd_data <= fl_rdata_i;
    end else if (cmd_take && cmd_ok && cmd == `FRG_CMD_STATUS) begin
      rd_data <= status;
    end
  end

  // sticky refusal flag; a new refusal wins over a clear
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refused <= 1'b0;
    end else if (set_refuse) begin
      refused <= 1'b1;
    end else if (clr_refuse) begin
      refused <= 1'b0;
    end
  end

  // programmer answers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pgm_ack_o <= 1'b0;
      pgm_nak_o <= 1'b0;
      pgm_rdata_o <= 8'h00;
    end else begin
      pgm_ack_o <= 1'b0;
      pgm_nak_o <= 1'b0;
      if (pgm_take && cmd_take && !cmd_ok) begin
        pgm_nak_o <= 1'b1;
      end else if (pgm_take && cmd_take && !cmd_flash) begin
        pgm_ack_o <= 1'b1;
        pgm_rdata_o <= status;
      end else if (state == frg_pkg::FRG_ST_BUSY && fl_done_i && op_from_pgm) begin
        pgm_ack_o <= 1'b1;
        pgm_rdata_o <= fl_rdata_i;
      end
    end
  end

  // wishbone slave: one wait state, unmapped reads zero
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `FRG_REG_CTRL_A: wb_dat_o <= {29'h0, ctrl_a};
          `FRG_REG_CTRL_B: wb_dat_o <= {30'h0, ctrl_b};
          `FRG_REG_ADDR: wb_dat_o <= {12'h0, addr_reg};
          `FRG_REG_CMD: wb_dat_o <= {24'h0, rd_data};
          `FRG_REG_STAT: wb_dat_o <= {24'h0, status};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_a <= `FRG_CTRL_A_RST;
      ctrl_b <= `FRG_CTRL_B_RST;
      addr_reg <= 20'h00000;
    end else if (wb_req && wb_we_i) begin
      if (wb_adr_i == `FRG_REG_CTRL_A && wb_sel_i[0]) begin
        ctrl_a <= wb_dat_i[2:0];
      end
      if (wb_adr_i == `FRG_REG_CTRL_B && wb_sel_i[0]) begin
        ctrl_b <= wb_dat_i[1:0];
      end
      if (wb_adr_i == `FRG_REG_ADDR) begin
        if (wb_sel_i[0]) addr_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) addr_reg[15:8] <= wb_dat_i[15:8];
        if (wb_sel_i[2]) addr_reg[19:16] <= wb_dat_i[19:16];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fl_boot_area_o <= 1'b0;
      cpu_stall_o <= 1'b0;
    end else begin
      fl_boot_area_o <= (mode_q == `FRG_MODE_BOOT);
      // flash-resident routine waits while flash is busy
      cpu_stall_o <= ctrl_a[`FRG_A_FLASH_EXEC] && mode_q == `FRG_MODE_SINGLE
        && (fl_req_o || cmd_take && cmd_ok && cmd_flash);
    end
  end

endmodule

// ### common/frg_cfg.svh
/*
 * Constants of the flash rewrite guard: register offsets, field positions,
 * reset values, mode and command codes, block bounds and ID locations.
 * Assumes a 20-bit flash byte address and 32-bit classic Wishbone data.
 */
// Summary of operation
// - The guard serves CPU rewrite in single-chip mode, serial programmer rewrite in boot mode and parallel programmer rewrite in parallel mode.
// - Flash is programmed or erased only through one of five commands, programming a byte at a time and erasing whole blocks.
// - In CPU rewrite mode program blocks 0 and 1 may be rewritten only while the global block rewrite enable is 1.
// - Program block 0 takes a rewrite only while its lock bit in the second control register is 0.
// - Program block 1 takes a rewrite only while its own lock bit in the second control register is 0.
// - CPU rewrite runs either with the routine in RAM or with the routine in flash itself.
// - The boot area holding the serial rewrite program overlays the user area addresses as separate storage chosen by mode.
// - The user area also holds two 1 Kbyte data blocks besides the program blocks.
// - The ID check works only in serial mode, while parallel mode uses a code protect against reads and rewrites.
// - In serial mode, unless the flash is blank, the received ID codes are compared with the stored ones.
// - After an ID mismatch no programmer command is acknowledged.
// - Seven ID bytes sit at fixed locations from 00FFDFh to 00FFFBh and the user image must place them there.
// - Code protect is active when the option byte has its protect bit at 0 and its qualify bit at 1.
// - Under code protect parallel mode cannot rewrite, and only erasing the option byte block by CPU or serial mode lifts it.
`ifndef FRG_CFG_SVH
`define FRG_CFG_SVH

`define FRG_REG_CTRL_A 8'h00
`define FRG_REG_CTRL_B 8'h04
`define FRG_REG_ADDR 8'h08
`define FRG_REG_CMD 8'h0c
`define FRG_REG_STAT 8'h10

`define FRG_A_RAM_EXEC 0
`define FRG_A_FLASH_EXEC 1
`define FRG_A_PROG_EN 2
`define FRG_B_LOCK0 0
`define FRG_B_LOCK1 1
`define FRG_CTRL_A_RST 3'h0
`define FRG_CTRL_B_RST 2'h3

`define FRG_S_BUSY 0
`define FRG_S_REFUSED 1
`define FRG_S_ID_OK 2
`define FRG_S_PROTECT 3
`define FRG_S_MODE_LO 4

`define FRG_MODE_SINGLE 2'h0
`define FRG_MODE_BOOT 2'h1
`define FRG_MODE_PARALLEL 2'h2

`define FRG_CMD_READ 3'h0
`define FRG_CMD_STATUS 3'h1
`define FRG_CMD_CLEAR 3'h2
`define FRG_CMD_PROG 3'h3
`define FRG_CMD_ERASE 3'h4

`define FRG_OP_READ 2'h0
`define FRG_OP_PROG 2'h1
`define FRG_OP_ERASE 2'h2

`define FRG_BLK0_LO 20'h0c000
`define FRG_BLK0_HI 20'h0ffff
`define FRG_BLK1_LO 20'h08000
`define FRG_BLK1_HI 20'h0bfff
`define FRG_BLKA_LO 20'h02400
`define FRG_BLKA_HI 20'h027ff
`define FRG_BLKB_LO 20'h02800
`define FRG_BLKB_HI 20'h02bff

`define FRG_ID0_ADDR 20'h0ffdf
`define FRG_ID1_ADDR 20'h0ffe3
`define FRG_ID2_ADDR 20'h0ffeb
`define FRG_ID3_ADDR 20'h0ffef
`define FRG_ID4_ADDR 20'h0fff3
`define FRG_ID5_ADDR 20'h0fff7
`define FRG_ID6_ADDR 20'h0fffb
`define FRG_OPT_ADDR 20'h0ffff
`define FRG_ID_COUNT 7
`define FRG_OPT_PROT_BIT 3
`define FRG_OPT_QUAL_BIT 2
`define FRG_ERASED_BYTE 8'hff

`endif

// ### common/frg_pkg.sv
/*
 * Types shared by the flash rewrite guard modules.
 * Assumes frg_cfg.svh supplies the numeric constants.
 */
package frg_pkg;

  typedef enum logic [2:0] {
    FRG_ST_IDLE,
    FRG_ST_SAMPLE,
    FRG_ST_READY,
    FRG_ST_BUSY,
    FRG_ST_HOLD
  } frg_state_type;

  typedef enum logic [2:0] {
    FRG_BLK_0,
    FRG_BLK_1,
    FRG_BLK_A,
    FRG_BLK_B,
    FRG_BLK_NONE
  } frg_block_type;

endpackage

// ### hdl/frg_id_check.sv
/*
 * ID code comparison: holds the seven stored ID bytes and one match flag
 * per byte. Assumes stored bytes are loaded before any received byte counts.
 */
`timescale 1ns/1ps
`include "frg_cfg.svh"

module frg_id_check (
  input wire logic clock_i, // system clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic clear_i, // new sampling starts
  input wire logic st_we_i, // stored byte strobe
  input wire logic [2:0] st_idx_i, // stored byte index
  input wire logic [7:0] st_byte_i, // stored byte value
  input wire logic rx_we_i, // received byte strobe
  input wire logic [2:0] rx_idx_i, // received byte index
  input wire logic [7:0] rx_byte_i, // received byte value
  output logic id_ok_o // blank flash or all bytes match
);

  logic [7:0] stored [`FRG_ID_COUNT];
  logic [`FRG_ID_COUNT-1:0] match;
  logic [`FRG_ID_COUNT-1:0] blank;

  genvar g;
  generate
    for (g = 0; g < `FRG_ID_COUNT; g++) begin : g_id
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          stored[g] <= `FRG_ERASED_BYTE;
        end else if (st_we_i && st_idx_i == 3'(g)) begin
          stored[g] <= st_byte_i;
        end
      end

      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          match[g] <= 1'b0;
        end else if (clear_i) begin
          match[g] <= 1'b0;
        end else if (rx_we_i && rx_idx_i == 3'(g)) begin
          match[g] <= (rx_byte_i == stored[g]);
        end
      end

      assign blank[g] = (stored[g] == `FRG_ERASED_BYTE);
    end
  endgenerate

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      id_ok_o <= 1'b0;
    end else begin
      id_ok_o <= (&blank) | (&match);
    end
  end

endmodule

// ### verif/frg_flash_model.sv
/* Behavioural flash array facing the guard.
   Assumes one request at a time, held until done_o. */
`timescale 1ns/1ps
`include "frg_cfg.svh"
module frg_flash_model (
  input wire logic clock_i, // clock
  input wire logic rst_b_i, // reset, active low
  input wire logic req_i, // request
  input wire logic [1:0] op_i, // operation
  input wire logic [19:0] addr_i, // byte address
  input wire logic [7:0] wdata_i, // program byte
  input wire logic slow_i, // late answers
  output logic [7:0] rdata_o, // read byte
  output logic done_o // done pulse
);
  logic [7:0] mem [logic [19:0]];
  logic [3:0] wait_cnt;
  function automatic logic [7:0] peek(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : `FRG_ERASED_BYTE;
  endfunction
  function automatic void poke(input logic [19:0] a, input logic [7:0] d);
    mem[a] = d;
  endfunction
  // erase clears a whole block, data blocks included
  task automatic erase_block(input logic [19:0] a);
    logic [19:0] lo;
    logic [19:0] hi;
    lo = (a >= `FRG_BLK0_LO) ? `FRG_BLK0_LO : (a >= `FRG_BLK1_LO) ? `FRG_BLK1_LO :
         (a >= `FRG_BLKB_LO) ? `FRG_BLKB_LO : `FRG_BLKA_LO;
    hi = (a >= `FRG_BLK0_LO) ? `FRG_BLK0_HI : (a >= `FRG_BLK1_LO) ? `FRG_BLK1_HI :
         (a >= `FRG_BLKB_LO) ? `FRG_BLKB_HI : `FRG_BLKA_HI;
    for (int i = int'(lo); i <= int'(hi); i++) begin
      if (mem.exists(20'(i))) mem.delete(20'(i));
    end
  endtask
  // idle read data toggles so a stale byte never passes for an answer
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
      wait_cnt <= 4'h0;
      rdata_o <= 8'h00;
    end else if (req_i && !done_o && wait_cnt >= (slow_i ? 4'h5 : 4'h1)) begin
      done_o <= 1'b1;
      wait_cnt <= 4'h0;
      rdata_o <= peek(addr_i);
      // byte programming can only clear bits
      if (op_i == `FRG_OP_PROG) poke(addr_i, peek(addr_i) & wdata_i);
      if (op_i == `FRG_OP_ERASE) erase_block(addr_i);
    end else begin
      done_o <= 1'b0;
      wait_cnt <= (req_i && !done_o) ? wait_cnt + 4'h1 : 4'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// ### verif/frg_guard_sva.sv
/* Port-level checker for the rewrite guard.
   Assumes the bench resets the guard before every mode change. */
`timescale 1ns/1ps
`include "frg_cfg.svh"
module frg_guard_sva (
  input wire logic clock_i, // clock
  input wire logic rst_b_i, // reset, active low
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_ack_o, // bus ack
  input wire logic [1:0] mode_i, // mode
  input wire logic pgm_ack_o, // programmer ack
  input wire logic pgm_nak_o, // programmer nak
  input wire logic fl_req_o, // flash request
  input wire logic [1:0] fl_op_o, // flash op
  input wire logic [19:0] fl_addr_o, // flash address
  input wire logic fl_done_i, // flash done
  input wire logic fl_boot_area_o, // boot area select
  input wire logic cpu_stall_o // cpu stall
);
  logic [3:0] n_done;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      n_done <= 4'h0;
    end else if (fl_done_i && n_done != 4'hf) begin
      n_done <= n_done + 4'h1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence wb_taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence cmd_done;
    fl_req_o && fl_done_i && fl_op_o != `FRG_OP_READ && mode_i != `FRG_MODE_SINGLE;
  endsequence
  sequence answered; pgm_ack_o || pgm_nak_o; endsequence
  chk_wb_ack_once: assert property (wb_taken |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  chk_ack_after_done: assert property (cmd_done |=> pgm_ack_o)
    else $error("no ack after flash op");
  chk_answer_once: assert property (answered |=> !pgm_ack_o && !pgm_nak_o)
    else $error("programmer answer too long");
  chk_req_held: assert property (fl_req_o && !fl_done_i |=>
    fl_req_o && $stable(fl_addr_o) && $stable(fl_op_o))
    else $error("flash request changed early");
  chk_boot_area_sel: assert property ($stable(mode_i)[*4] |->
    fl_boot_area_o == (mode_i == `FRG_MODE_BOOT))
    else $error("boot area select wrong");
  chk_stall_cpu_only: assert property (cpu_stall_o |-> mode_i == `FRG_MODE_SINGLE)
    else $error("stall outside cpu mode");
  chk_single_quiet: assert property (mode_i == `FRG_MODE_SINGLE |->
    !pgm_ack_o && !pgm_nak_o)
    else $error("programmer answered in cpu mode");
  chk_sample_first: assert property ((pgm_ack_o || (fl_req_o && fl_op_o != `FRG_OP_READ))
    |-> n_done >= 4'h8)
    else $error("command before ID sampling");
  chk_first_id_addr: assert property (fl_req_o && n_done == 4'h0 |->
    fl_addr_o == `FRG_ID0_ADDR)
    else $error("first sample not at first ID");
  chk_opt_sampled: assert property (fl_req_o && n_done == 4'h7 |->
    fl_addr_o == `FRG_OPT_ADDR && fl_op_o == `FRG_OP_READ)
    else $error("option byte not sampled");
endmodule
bind frg_guard frg_guard_sva chk_u (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .mode_i(mode_i), .pgm_ack_o(pgm_ack_o), .pgm_nak_o(pgm_nak_o),
  .fl_req_o(fl_req_o), .fl_op_o(fl_op_o), .fl_addr_o(fl_addr_o), .fl_done_i(fl_done_i),
  .fl_boot_area_o(fl_boot_area_o), .cpu_stall_o(cpu_stall_o)
);

// ### verif/tb_top.sv
/* Self-checking bench: CPU gating, parallel protect, serial ID check.
   Assumes the flash model answers every request. */
`timescale 1ns/1ps
`include "frg_cfg.svh"
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
  logic clock, rst_b, wb_cyc, wb_stb, wb_we, wb_ack, pgm_valid, pgm_id_we, pgm_ack, pgm_nak;
  logic fl_req, fl_done, boot_area, slow;
  logic [1:0] mode, fl_op, res;
  logic [2:0] pgm_cmd, pgm_id_idx;
  logic [7:0] wb_adr, pgm_data, pgm_rdata, fl_wdata, fl_rdata;
  logic [19:0] pgm_addr, fl_addr;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [7:0] idv [7];
  logic [19:0] id_adr [7];
  int n_mismatch, checked;
  frg_guard dut_u (.clock_i(clock), .rst_b_i(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .mode_i(mode), .pgm_valid_i(pgm_valid),
    .pgm_cmd_i(pgm_cmd), .pgm_addr_i(pgm_addr), .pgm_data_i(pgm_data),
    .pgm_id_we_i(pgm_id_we), .pgm_id_idx_i(pgm_id_idx), .pgm_ack_o(pgm_ack),
    .pgm_nak_o(pgm_nak), .pgm_rdata_o(pgm_rdata), .fl_req_o(fl_req), .fl_op_o(fl_op),
    .fl_addr_o(fl_addr), .fl_wdata_o(fl_wdata), .fl_rdata_i(fl_rdata), .fl_done_i(fl_done),
    .fl_boot_area_o(boot_area), .cpu_stall_o());
  frg_flash_model flash_u (.clock_i(clock), .rst_b_i(rst_b), .req_i(fl_req), .op_i(fl_op),
    .addr_i(fl_addr), .wdata_i(fl_wdata), .slow_i(slow), .rdata_o(fl_rdata), .done_o(fl_done));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do @(posedge clock); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic cpu_cmd(input logic [2:0] c, input logic [19:0] a, input logic [7:0] d);
    wb_io(1'b1, `FRG_REG_ADDR, {12'h000, a});
    wb_io(1'b1, `FRG_REG_CMD, {21'h000000, c, d});
    do wb_io(1'b0, `FRG_REG_STAT, 32'h0); while (rd[`FRG_S_BUSY] !== 1'b0);
  endtask
  task automatic pgm_req(input logic [2:0] c, input logic [19:0] a, input logic [7:0] d);
    @(posedge clock);
    pgm_valid <= 1'b1;
    pgm_cmd <= c;
    pgm_addr <= a;
    pgm_data <= d;
    res = 2'h2;
    // a refused ID check never answers: bounded wait
    for (int i = 0; i < 40 && res == 2'h2; i++) begin
      @(posedge clock);
      if (pgm_ack === 1'b1) res = 2'h0;
      else if (pgm_nak === 1'b1) res = 2'h1;
    end
    pgm_valid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic send_ids(input int wrong);
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      pgm_id_we <= 1'b1;
      pgm_id_idx <= 3'(i);
      pgm_data <= idv[i] ^ ((i == wrong) ? 8'h01 : 8'h00);
      @(posedge clock);
      pgm_id_we <= 1'b0;
    end
  endtask
  // fixed wait covers the eight sampling reads, slow ones too
  task automatic do_reset(input logic [1:0] m);
    rst_b <= 1'b0;
    mode <= m;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    repeat (120) @(posedge clock);
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    static logic [2:0] ta [6] = '{3'h4, 3'h5, 3'h5, 3'h6, 3'h5, 3'h1};
    static logic [1:0] tl [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h0};
    static logic [19:0] tadr [6] = '{`FRG_BLK0_LO, `FRG_BLK0_LO + 20'h1, `FRG_BLK1_LO,
      `FRG_BLK1_LO + 20'h3, `FRG_BLK0_LO + 20'h4, `FRG_BLKA_LO};
    static logic [5:0] tok = 6'b111000;
    {rst_b, wb_cyc, wb_stb, wb_we, pgm_valid, pgm_id_we, slow} = '0;
    {wb_adr, wb_wdat, mode, pgm_cmd, pgm_id_idx, pgm_addr, pgm_data} = '0;
    id_adr = '{`FRG_ID0_ADDR, `FRG_ID1_ADDR, `FRG_ID2_ADDR, `FRG_ID3_ADDR, `FRG_ID4_ADDR,
      `FRG_ID5_ADDR, `FRG_ID6_ADDR};
    for (int i = 0; i < 7; i++) idv[i] = 8'h31 + 8'(i);
    do_reset(`FRG_MODE_SINGLE);
    wb_io(1'b0, `FRG_REG_CTRL_A, 32'h0);
    `CHK("ctrl_a reset", `FRG_CTRL_A_RST, rd[2:0])
    wb_io(1'b0, `FRG_REG_CTRL_B, 32'h0);
    `CHK("ctrl_b reset", `FRG_CTRL_B_RST, rd[1:0])
    wb_io(1'b0, 8'h20, 32'hffffffff);
    `CHK("unmapped read", 32'h0, rd)
    for (int k = 0; k < 6; k++) begin
      wb_io(1'b1, `FRG_REG_CTRL_A, {29'h0, ta[k]});
      wb_io(1'b1, `FRG_REG_CTRL_B, {30'h0, tl[k]});
      cpu_cmd(`FRG_CMD_CLEAR, 20'h0, 8'h00);
      cpu_cmd(`FRG_CMD_PROG, tadr[k], 8'h50 + 8'(k));
      `CHK("cpu refused", !tok[k], rd[`FRG_S_REFUSED])
      `CHK("cpu byte", tok[k] ? 8'h50 + 8'(k) : 8'hff, flash_u.peek(tadr[k]))
    end
    cpu_cmd(`FRG_CMD_ERASE, `FRG_BLK1_LO, 8'h00);
    `CHK("gated erase", 8'h53, flash_u.peek(`FRG_BLK1_LO + 20'h3))
    for (int i = 0; i < 7; i++) flash_u.poke(id_adr[i], idv[i]);
    flash_u.poke(`FRG_OPT_ADDR, 8'hf7);
    do_reset(`FRG_MODE_PARALLEL);
    wb_io(1'b0, `FRG_REG_STAT, 32'h0);
    `CHK("protect on", 1'b1, rd[`FRG_S_PROTECT])
    `CHK("user area", 1'b0, boot_area)
    pgm_req(`FRG_CMD_STATUS, 20'h0, 8'h00);
    `CHK("parallel no id", 2'h0, res)
    pgm_req(`FRG_CMD_PROG, `FRG_BLK0_LO + 20'h8, 8'h77);
    `CHK("protected nak", 2'h1, res)
    `CHK("protected byte", 8'hff, flash_u.peek(`FRG_BLK0_LO + 20'h8))
    do_reset(`FRG_MODE_BOOT);
    `CHK("boot area", 1'b1, boot_area)
    pgm_req(`FRG_CMD_READ, `FRG_BLK0_LO, 8'h00);
    `CHK("no id silent", 2'h2, res)
    flash_u.poke(`FRG_ID0_ADDR, 8'h00);
    send_ids(3);
    pgm_req(`FRG_CMD_READ, `FRG_BLK0_LO, 8'h00);
    `CHK("bad id silent", 2'h2, res)
    send_ids(7);
    pgm_req(`FRG_CMD_READ, `FRG_ID1_ADDR, 8'h00);
    `CHK("id ok ack", 2'h0, res)
    `CHK("id byte read", idv[1], pgm_rdata)
    pgm_req(`FRG_CMD_ERASE, `FRG_BLK0_LO, 8'h00);
    `CHK("option erased", 8'hff, flash_u.peek(`FRG_OPT_ADDR))
    slow <= 1'b1;
    do_reset(`FRG_MODE_PARALLEL);
    wb_io(1'b0, `FRG_REG_STAT, 32'h0);
    `CHK("protect off", 1'b0, rd[`FRG_S_PROTECT])
    pgm_req(`FRG_CMD_PROG, `FRG_BLK0_LO + 20'h8, 8'h77);
    `CHK("parallel prog", 8'h77, flash_u.peek(`FRG_BLK0_LO + 20'h8))
    report_and_stop();
  end
endmodule
